// ---- pcrb_defines.svh ----
/*
  named offsets, field positions, reset values and timing figures of the paged control bank.
  assumes inclusion by bare name; definitions only.
*/
`ifndef PCRB_DEFINES_SVH
`define PCRB_DEFINES_SVH

`define PCRB_PAGE_DRV 8'h01
`define PCRB_PAGE_TMR 8'h03
`define PCRB_PAGE_COEF 8'h08

`define PCRB_REG_PAGE 7'h00
`define PCRB_REG_OUTMODE 7'h2C
`define PCRB_REG_RSVD_2D 7'h2D
`define PCRB_REG_BIAS 7'h2E
`define PCRB_REG_ICM 7'h32
`define PCRB_REG_RSVD_TAIL 7'h33
`define PCRB_REG_TMR_DIV 7'h10
`define PCRB_REG_COEF_CTRL 7'h01
`define PCRB_REG_COEF_FIRST 7'h02
`define PCRB_REG_COEF_LAST 7'h41

`define PCRB_OUTMODE_LEFT 2
`define PCRB_OUTMODE_RIGHT 1
`define PCRB_DBN_MSB 7
`define PCRB_DBN_LSB 5
`define PCRB_BIAS_SPD 7
`define PCRB_BIAS_FORCE 3
`define PCRB_BIAS_LVL_MSB 1
`define PCRB_BIAS_LVL_LSB 0
`define PCRB_ICM_FIRST 7
`define PCRB_ICM_SECOND 6
`define PCRB_TMR_SRC 7
`define PCRB_TMR_DIV_MSB 6
`define PCRB_CTRL_ADAPT 2
`define PCRB_CTRL_SEL 1
`define PCRB_CTRL_SWAP 0

`define PCRB_PAGE_RST 8'h00
`define PCRB_OUTMODE_RST 8'h00
`define PCRB_BIAS_RST 8'h00
`define PCRB_ICM_RST 8'h00
`define PCRB_TMR_DIV_RST 8'h81
`define PCRB_DIV_ZERO 8'h80

`define PCRB_COEF_NUM 32
`define PCRB_COEF_PER_BIQUAD 5
`define PCRB_COEF_FILT_NUM 30
`define PCRB_COEF_UNITY 16'h7FFF
`define PCRB_COEF_ZERO 16'h0000

`define PCRB_CLK_NS 50
`define PCRB_INIT_TIME_NS 100000
`define PCRB_INIT_CYCLES ((`PCRB_INIT_TIME_NS + `PCRB_CLK_NS - 1) / `PCRB_CLK_NS)
`define PCRB_INIT_W 11
`define PCRB_NPIN 5
`define PCRB_ADDR_W 12
`define PCRB_IDX_MSB 8
`define PCRB_IDX_LSB 2

`endif

// ---- pcrb_pkg.sv ----
/*
  types of the paged control bank: pin order and the packed state record.
  assumes pcrb_defines.svh is on the include path.
*/
`include "pcrb_defines.svh"

package pcrb_pkg;

  typedef enum logic [2:0] {
    PCRB_PIN_MCLK = 3'b000,
    PCRB_PIN_OSC = 3'b001,
    PCRB_PIN_FRAME = 3'b010,
    PCRB_PIN_HSDET = 3'b011,
    PCRB_PIN_HSINS = 3'b100
  } pcrb_pin_e;

  typedef logic [`PCRB_COEF_NUM-1:0][15:0] pcrb_coef_t;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] outmode;
    logic [7:0] bias;
    logic [7:0] icm;
    logic [7:0] tmr_div;
    logic adapt;
    logic sel;
    logic swap_req;
    logic [7:0] stage;
    pcrb_coef_t buf_a;
    pcrb_coef_t buf_b;
    logic [`PCRB_INIT_W-1:0] init_cnt;
    logic init_done;
    logic [`PCRB_NPIN-1:0] pin_s1;
    logic [`PCRB_NPIN-1:0] pin_s2;
    logic [`PCRB_NPIN-1:0] pin_s3;
    logic [`PCRB_NPIN-1:0] pin_f;
    logic [7:0] mclk_cnt;
    logic [7:0] osc_cnt;
    logic timer_tick;
    logic [7:0] dbn_cnt;
    logic dbn_tick;
    logic [31:0] prdata;
    logic pslverr;
    logic [15:0] dsp_coef;
  } pcrb_state_s;

endpackage : pcrb_pkg

// ---- pcrb_top.sv ----
/*
  paged control bank with double-buffered coefficient store, reached over apb.
  assumes a 20 mhz pclk, an apb master, and clock and status pins from other domains.
*/
// Our own choice: register access over APB.
//
// Contract
// - register 0 of every page selects page
// - timer and coefficient pages valid after 100 us
// - timer source bit: oscillator or master clock
// - master clock paces delay timer only
// - coefficient is signed 16 bits, high then low
// - control bit 2 enables adaptive filtering
// - read-only bit 1 shows buffer assignment
// - bit 0 requests swap at frame boundary
// - swap clears request and toggles buffer flag
// - bit 2 sets left driver to line out
// - bit 1 sets right driver to line out
// - bias bit 7 enables software power-down
// - bias bit 3 forces bias without headset
// - two-bit field selects bias output level
// - bits 7,6 tie unused inputs to common mode
// - debounce clock period is duration over eight
// - first coefficient high byte at register 2
`timescale 1ns/1ps
`default_nettype none
`include "pcrb_defines.svh"

module pcrb_top
  import pcrb_pkg::*;
#(
  parameter logic [7:0] OSC_DIV = 8'd8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PCRB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mclk_in,
  input wire logic osc_in,
  input wire logic frame_start_in,
  input wire logic headset_detect_en_in,
  input wire logic headset_inserted_in,
  input wire logic [4:0] dsp_coef_idx,
  output logic [15:0] dsp_coef,
  output logic left_phones_driver_lineout,
  output logic right_phones_driver_lineout,
  output logic soft_powerdown_en,
  output logic [1:0] mic_bias_output,
  output logic analog_input_first_cm_tie,
  output logic analog_input_second_cm_tie,
  output logic adaptive_en,
  output logic dsp_buffer_sel,
  output logic timer_tick,
  output logic debounce_tick,
  output logic defaults_valid
);

  localparam int INIT_CYCLES = `PCRB_INIT_CYCLES;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic pcrb_coef_t coef_defaults();
    pcrb_coef_t c;
    for (int i = 0; i < `PCRB_COEF_NUM; i++) begin
      c[i] = ((i % `PCRB_COEF_PER_BIQUAD) == 0 && i < `PCRB_COEF_FILT_NUM) ? `PCRB_COEF_UNITY : `PCRB_COEF_ZERO;
    end
    return c;
  endfunction : coef_defaults

  localparam pcrb_coef_t COEF_RST = coef_defaults();

  pcrb_state_s st;
  pcrb_state_s next_st;

  logic [`PCRB_NPIN-1:0] pin_in;
  logic [`PCRB_NPIN-1:0] pin_rise;
  logic [6:0] idx;
  logic addr_bad;
  logic page_gated;
  logic is_coef;
  logic [4:0] coef_idx;
  logic host_b;
  logic dsp_b;
  logic wr_acc;
  logic setup;
  logic swap_now;
  logic [7:0] divisor;
  logic [7:0] dbn_period;
  logic [2:0] dbn_code;
  logic src_edge;
  logic [15:0] host_word;
  logic [7:0] rd_byte;
  logic drv_wr;
  logic coef_wr;

  assign pin_in = {headset_inserted_in, headset_detect_en_in, frame_start_in, osc_in, mclk_in};

  // a rising pin edge counts once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < `PCRB_NPIN; g++) begin : g_pin
      assign pin_rise[g] = st.pin_s2[g] & st.pin_s3[g] & ~st.pin_f[g];
    end
  endgenerate

  always_comb begin
    idx = paddr[`PCRB_IDX_MSB:`PCRB_IDX_LSB];
    addr_bad = |paddr[`PCRB_ADDR_W-1:`PCRB_IDX_MSB+1] | (|paddr[1:0]);
    // pages 3 and 8 answer, except at register 0, only once their defaults are valid
    page_gated = (idx != `PCRB_REG_PAGE) & ~st.init_done &
                 ((st.page == `PCRB_PAGE_TMR) | (st.page == `PCRB_PAGE_COEF));
    is_coef = (st.page == `PCRB_PAGE_COEF) & (idx >= `PCRB_REG_COEF_FIRST) &
              (idx <= `PCRB_REG_COEF_LAST);
    coef_idx = 5'((idx - `PCRB_REG_COEF_FIRST) >> 1);
    host_b = st.adapt & ~st.sel;
    dsp_b = st.adapt & st.sel;
    host_word = host_b ? st.buf_b[coef_idx] : st.buf_a[coef_idx];
    setup = psel & ~penable;
    wr_acc = psel & penable & pwrite & ~st.pslverr;
    drv_wr = wr_acc & pstrb[0] & (st.page == `PCRB_PAGE_DRV);
    coef_wr = wr_acc & pstrb[0] & (st.page == `PCRB_PAGE_COEF);
    swap_now = pin_rise[PCRB_PIN_FRAME] & st.swap_req & st.adapt;
    divisor = (st.tmr_div[`PCRB_TMR_DIV_MSB:0] == 7'h00) ? `PCRB_DIV_ZERO :
              {1'b0, st.tmr_div[`PCRB_TMR_DIV_MSB:0]};
    dbn_code = st.outmode[`PCRB_DBN_MSB:`PCRB_DBN_LSB];
    dbn_period = (dbn_code == 3'h0) ? 8'h01 : 8'(8'h01 << (dbn_code - 3'h1));
    src_edge = st.tmr_div[`PCRB_TMR_SRC] ? pin_rise[PCRB_PIN_MCLK] : 1'b0;
  end

  always_comb begin
    rd_byte = 8'h00;
    if (idx == `PCRB_REG_PAGE) begin
      rd_byte = st.page;
    end else if (st.page == `PCRB_PAGE_DRV) begin
      case (idx)
        `PCRB_REG_OUTMODE: rd_byte = st.outmode;
        `PCRB_REG_BIAS: rd_byte = st.bias;
        `PCRB_REG_ICM: rd_byte = st.icm;
        default: rd_byte = 8'h00;
      endcase
    end else if (st.page == `PCRB_PAGE_TMR) begin
      rd_byte = (idx == `PCRB_REG_TMR_DIV) ? st.tmr_div : 8'h00;
    end else if (st.page == `PCRB_PAGE_COEF) begin
      if (idx == `PCRB_REG_COEF_CTRL) begin
        rd_byte = {5'h00, st.adapt, st.sel, st.swap_req};
      end else if (is_coef) begin
        rd_byte = idx[0] ? host_word[7:0] : host_word[15:8];
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.timer_tick = 1'b0;
    next_st.dbn_tick = 1'b0;
    // pin synchronisers
    next_st.pin_s1 = pin_in;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_s3 = st.pin_s2;
    for (int i = 0; i < `PCRB_NPIN; i++) begin
      if (st.pin_s2[i] == st.pin_s3[i]) begin
        next_st.pin_f[i] = st.pin_s3[i];
      end
    end
    // power-up wait before defaults count as valid
    if (!st.init_done) begin
      if (st.init_cnt == `PCRB_INIT_W'(INIT_CYCLES - 1)) begin
        next_st.init_done = 1'b1;
      end else begin
        next_st.init_cnt = st.init_cnt + `PCRB_INIT_W'(1);
      end
    end
    // delay-timer clock
    if (st.tmr_div[`PCRB_TMR_SRC]) begin
      if (src_edge) begin
        if (st.mclk_cnt + 8'h01 >= divisor) begin
          next_st.mclk_cnt = 8'h00;
          next_st.timer_tick = 1'b1;
        end else begin
          next_st.mclk_cnt = st.mclk_cnt + 8'h01;
        end
      end
    end else if (pin_rise[PCRB_PIN_OSC]) begin
      if (st.osc_cnt + 8'h01 >= OSC_DIV) begin
        next_st.osc_cnt = 8'h00;
        next_st.timer_tick = 1'b1;
      end else begin
        next_st.osc_cnt = st.osc_cnt + 8'h01;
      end
    end
    // debounce clock from the timer clock
    if (st.timer_tick) begin
      if (st.dbn_cnt + 8'h01 >= dbn_period) begin
        next_st.dbn_cnt = 8'h00;
        next_st.dbn_tick = 1'b1;
      end else begin
        next_st.dbn_cnt = st.dbn_cnt + 8'h01;
      end
    end
    // buffer swap at frame start
    if (swap_now) begin
      next_st.sel = ~st.sel;
      next_st.swap_req = 1'b0;
    end
    // apb setup phase: decode and latch the answer
    if (setup) begin
      next_st.pslverr = addr_bad | page_gated;
      next_st.prdata = (addr_bad | page_gated | pwrite) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
    // apb access phase: writes take effect
    if (wr_acc && pstrb[0]) begin
      if (idx == `PCRB_REG_PAGE) begin
        next_st.page = pwdata[7:0];
      end else if (st.page == `PCRB_PAGE_DRV) begin
        case (idx)
          `PCRB_REG_OUTMODE: next_st.outmode = pwdata[7:0];
          `PCRB_REG_BIAS: next_st.bias = pwdata[7:0];
          `PCRB_REG_ICM: next_st.icm = pwdata[7:0];
          default: next_st.page = st.page;
        endcase
      end else if (st.page == `PCRB_PAGE_TMR) begin
        if (idx == `PCRB_REG_TMR_DIV) begin
          next_st.tmr_div = pwdata[7:0];
          // restart the count so it never sits above a smaller divisor
          next_st.mclk_cnt = 8'h00;
        end
      end else if (st.page == `PCRB_PAGE_COEF) begin
        if (idx == `PCRB_REG_COEF_CTRL) begin
          next_st.adapt = pwdata[`PCRB_CTRL_ADAPT];
          // a request written during a swap survives it
          if (pwdata[`PCRB_CTRL_SWAP]) begin
            next_st.swap_req = 1'b1;
          end else if (!swap_now) begin
            next_st.swap_req = 1'b0;
          end
        end else if (is_coef) begin
          if (!idx[0]) begin
            next_st.stage = pwdata[7:0];
          end else if (host_b) begin
            next_st.buf_b[coef_idx] = {st.stage, pwdata[7:0]};
          end else begin
            next_st.buf_a[coef_idx] = {st.stage, pwdata[7:0]};
          end
        end
      end
    end
    // coefficient word for the processing block
    next_st.dsp_coef = dsp_b ? st.buf_b[dsp_coef_idx] : st.buf_a[dsp_coef_idx];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.page <= `PCRB_PAGE_RST;
      st.outmode <= `PCRB_OUTMODE_RST;
      st.bias <= `PCRB_BIAS_RST;
      st.icm <= `PCRB_ICM_RST;
      st.tmr_div <= `PCRB_TMR_DIV_RST;
      st.buf_a <= COEF_RST;
      st.buf_b <= COEF_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = 1'b1;
  assign pslverr = st.pslverr & psel & penable;
  assign dsp_coef = st.dsp_coef;
  assign left_phones_driver_lineout = st.outmode[`PCRB_OUTMODE_LEFT];
  assign right_phones_driver_lineout = st.outmode[`PCRB_OUTMODE_RIGHT];
  assign soft_powerdown_en = st.bias[`PCRB_BIAS_SPD];
  // bias stays off with detection on and no headset unless forced
  assign mic_bias_output = (st.bias[`PCRB_BIAS_FORCE] | ~st.pin_f[PCRB_PIN_HSDET] | st.pin_f[PCRB_PIN_HSINS]) ?
                           st.bias[`PCRB_BIAS_LVL_MSB:`PCRB_BIAS_LVL_LSB] : 2'b00;
  assign analog_input_first_cm_tie = st.icm[`PCRB_ICM_FIRST];
  assign analog_input_second_cm_tie = st.icm[`PCRB_ICM_SECOND];
  assign adaptive_en = st.adapt;
  assign dsp_buffer_sel = st.sel;
  assign timer_tick = st.timer_tick;
  assign debounce_tick = st.dbn_tick;
  assign defaults_valid = st.init_done;

  // checks

  chk_page_write: assert property (wr_acc && pstrb[0] && idx == `PCRB_REG_PAGE |=> st.page == $past(pwdata[7:0]))
    else $error("page selector not loaded");
  chk_init_gate: assert property (setup && !st.init_done && idx != `PCRB_REG_PAGE &&
                                  st.page == `PCRB_PAGE_COEF |=> pslverr)
    else $error("gated page answered before defaults valid");
  chk_init_time: assert property ($rose(st.init_done) |-> st.init_cnt == `PCRB_INIT_W'(INIT_CYCLES - 1))
    else $error("defaults valid at wrong time");
  chk_src_mclk: assert property (st.tmr_div[`PCRB_TMR_SRC] && !pin_rise[PCRB_PIN_MCLK] |=> !timer_tick)
    else $error("timer tick without master clock edge");
  chk_div_range: assert property (st.tmr_div[`PCRB_TMR_SRC] |-> st.mclk_cnt < divisor)
    else $error("divider count out of range");
  chk_swap_flip: assert property (swap_now |=> dsp_buffer_sel != $past(st.sel))
    else $error("buffer flag did not toggle on swap");
  chk_swap_clear: assert property (swap_now && !(wr_acc && idx == `PCRB_REG_COEF_CTRL) |=> !st.swap_req)
    else $error("swap request not cleared");
  chk_no_swap_idle: assert property (!st.adapt && !(wr_acc && idx == `PCRB_REG_COEF_CTRL) |=> $stable(st.sel))
    else $error("buffer flag moved with adaptive filtering off");
  chk_bias_gate: assert property (st.pin_f[PCRB_PIN_HSDET] && !st.pin_f[PCRB_PIN_HSINS] &&
                                  !st.bias[`PCRB_BIAS_FORCE] |-> mic_bias_output == 2'b00)
    else $error("bias on without headset");
  chk_coef_commit: assert property (wr_acc && pstrb[0] && is_coef && idx[0] && !host_b |=>
                                    st.buf_a[$past(coef_idx)] == {$past(st.stage), $past(pwdata[7:0])})
    else $error("coefficient not committed on low byte");
  chk_outmode_write: assert property (drv_wr && idx == `PCRB_REG_OUTMODE |=>
                                      left_phones_driver_lineout == $past(pwdata[`PCRB_OUTMODE_LEFT]) &&
                                      right_phones_driver_lineout == $past(pwdata[`PCRB_OUTMODE_RIGHT]))
    else $error("output mode bits not applied");
  chk_powerdown_write: assert property (drv_wr && idx == `PCRB_REG_BIAS |=>
                                        soft_powerdown_en == $past(pwdata[`PCRB_BIAS_SPD]))
    else $error("software power-down bit not applied");
  chk_bias_forced: assert property (drv_wr && idx == `PCRB_REG_BIAS && pwdata[`PCRB_BIAS_FORCE] |=>
                                    mic_bias_output == $past(pwdata[`PCRB_BIAS_LVL_MSB:`PCRB_BIAS_LVL_LSB]))
    else $error("forced bias level not applied");
  chk_cm_tie_write: assert property (drv_wr && idx == `PCRB_REG_ICM |=>
                                     analog_input_first_cm_tie == $past(pwdata[`PCRB_ICM_FIRST]) &&
                                     analog_input_second_cm_tie == $past(pwdata[`PCRB_ICM_SECOND]))
    else $error("common-mode tie bits not applied");
  chk_adapt_write: assert property (coef_wr && idx == `PCRB_REG_COEF_CTRL |=>
                                    adaptive_en == $past(pwdata[`PCRB_CTRL_ADAPT]))
    else $error("adaptive enable not applied");
  chk_sel_readonly: assert property (coef_wr && idx == `PCRB_REG_COEF_CTRL && !swap_now |=>
                                     dsp_buffer_sel == $past(st.sel))
    else $error("buffer flag written by host");
  chk_swap_wait: assert property (st.swap_req && !pin_rise[PCRB_PIN_FRAME] &&
                                  !(coef_wr && idx == `PCRB_REG_COEF_CTRL) |=> st.swap_req && $stable(st.sel))
    else $error("swap taken away from a frame start");
  chk_swap_needs_req: assert property (!st.swap_req |=> $stable(st.sel))
    else $error("buffers swapped without a request");
  chk_tick_pulse: assert property (timer_tick && $stable(st.tmr_div[`PCRB_TMR_SRC]) |=> !timer_tick)
    else $error("timer tick longer than one cycle");
  chk_osc_only: assert property (!st.tmr_div[`PCRB_TMR_SRC] && !pin_rise[PCRB_PIN_OSC] |=> !timer_tick)
    else $error("timer tick without oscillator edge");
  chk_dbn_source: assert property (!st.timer_tick |=> !debounce_tick)
    else $error("debounce tick without timer tick");
  chk_commit_b: assert property (coef_wr && is_coef && idx[0] && host_b |=>
                                 st.buf_b[$past(coef_idx)] == {$past(st.stage), $past(pwdata[7:0])})
    else $error("coefficient not committed to host buffer");
  chk_stage_only: assert property (coef_wr && is_coef && !idx[0] |=>
                                   $stable(st.buf_a) && $stable(st.buf_b))
    else $error("high byte changed a coefficient");
  chk_page_read: assert property (setup && !pwrite && !addr_bad && idx == `PCRB_REG_PAGE |=>
                                  prdata == {24'h00_0000, $past(st.page)})
    else $error("page selector read wrong");
  chk_init_hold: assert property (defaults_valid |=> defaults_valid)
    else $error("defaults valid dropped");

  cov_swap: cover property (swap_now);
  cov_commit: cover property (wr_acc && is_coef && idx[0]);
  cov_tick: cover property (debounce_tick);
  cov_gated: cover property (setup && page_gated);
  cov_swap_blocked: cover property (pin_rise[PCRB_PIN_FRAME] && st.swap_req && !st.adapt);

endmodule : pcrb_top
`default_nettype wire

// ---- pcrb_host.sv ----
/*
  apb host model of the paged control bank: two-phase transfers, request held until pready.
  assumes one calling process and a free-running pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pcrb_host (
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
  end
  // one transfer; callers keep timer page to reg 16, pairs high then low, no reserved writes
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : pcrb_host
`default_nettype wire

// ---- test_paged_ctrl_regs_coef_buffer.sv ----
/*
  self-checking bench of the paged control bank: bus, driver page, timer, coefficient swap.
  assumes pcrb_host as apb master and a 20 mhz pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module test_paged_ctrl_regs_coef_buffer;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [3:0] pstrb, mph;
  logic mclk_in, osc_in, frame_start_in, hs_en, hs_in, osc_run, left_lo, right_lo, spd, cm1, cm2;
  logic adaptive_en, dsp_buffer_sel, timer_tick, debounce_tick, defaults_valid;
  logic [1:0] mic_bias;
  logic [4:0] dsp_coef_idx, kk;
  logic [6:0] hi;
  logic [7:0] v;
  logic [15:0] dsp_coef, c1, c2;
  logic [33:0] notes[$];
  logic [33:0] note;
  int errors, total_checks, cyc, n;

  pcrb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mclk_in(mclk_in), .osc_in(osc_in), .frame_start_in(frame_start_in), .headset_detect_en_in(hs_en),
    .headset_inserted_in(hs_in), .dsp_coef_idx(dsp_coef_idx), .dsp_coef(dsp_coef),
    .left_phones_driver_lineout(left_lo), .right_phones_driver_lineout(right_lo), .soft_powerdown_en(spd),
    .mic_bias_output(mic_bias), .analog_input_first_cm_tie(cm1), .analog_input_second_cm_tie(cm2),
    .adaptive_en(adaptive_en), .dsp_buffer_sel(dsp_buffer_sel), .timer_tick(timer_tick),
    .debounce_tick(debounce_tick), .defaults_valid(defaults_valid));
  pcrb_host host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // master clock of 8 pclk, oscillator of 16 pclk when running
  always @(posedge pclk) begin
    mph <= mph + 4'h1;
    mclk_in <= mph[2];
    osc_in <= osc_run & mph[3];
    if (presetn) cyc <= cyc + 1;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // bus results: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      note = notes.pop_front();
      if (note[33]) chk("prdata", note[31:0], prdata);
      chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
    end
  end

  task automatic acc(input logic wr, input logic [6:0] idx, input logic [7:0] d, input logic err,
                     input logic [7:0] exp);
    notes.push_back({~wr, err, 24'h0, exp});
    host.xfer(wr, {3'h0, idx, 2'b00}, {24'h0, d});
  endtask : acc

  task automatic raw(input logic [11:0] a);
    notes.push_back({2'b11, 32'h0});
    host.xfer(1'b0, a, 32'h0);
  endtask : raw

  task automatic frame();
    frame_start_in <= 1'b1;
    repeat (5) @(posedge pclk);
    frame_start_in <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask : frame

  task automatic gap(input logic dbn, input int exp);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while ((dbn ? debounce_tick : timer_tick) !== 1'b1 && n < 4000);
    end
    chk(dbn ? "debounce gap" : "timer gap", exp, n);
  endtask : gap

  initial begin
    #(40000 * 50);
    errors++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    mph = 4'h0;
    mclk_in = 1'b0;
    osc_in = 1'b0;
    osc_run = 1'b0;
    frame_start_in = 1'b0;
    hs_en = 1'b0;
    hs_in = 1'b0;
    dsp_coef_idx = 5'h00;
    seed = 32'h000045FB;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    acc(0, 7'h00, 8'h00, 0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'hFF : 8'(rnd());
      acc(1, 7'h00, v, 0, 8'h00);
      acc(0, 7'h00, 8'h00, 0, v);
    end
    acc(1, 7'h00, 8'h03, 0, 8'h00);
    acc(0, 7'h10, 8'h00, 1, 8'h00);
    acc(1, 7'h00, 8'h08, 0, 8'h00);
    acc(0, 7'h01, 8'h00, 1, 8'h00);
    while (cyc < 1999) @(negedge pclk);
    chk("defaults_valid", 0, defaults_valid);
    @(negedge pclk);
    chk("defaults_valid", 1, defaults_valid);
    $display("test init done");
    acc(1, 7'h00, 8'h01, 0, 8'h00);
    acc(0, 7'h2E, 8'h00, 0, 8'h00);
    acc(0, 7'h2D, 8'h00, 0, 8'h00);
    acc(0, 7'h40, 8'h00, 0, 8'h00);
    raw(12'h0B1);
    raw(12'h200);
    for (int c = 0; c < 8; c++) begin
      v = 8'(rnd());
      v = {c[2:0], v[4:3], c[1:0], 1'b0};
      acc(1, 7'h2C, v, 0, 8'h00);
      acc(0, 7'h2C, 8'h00, 0, v);
      acc(1, 7'h32, {c[1:0], 6'h00}, 0, 8'h00);
      repeat (3) @(negedge pclk);
      chk("left lineout", c[1], left_lo);
      chk("right lineout", c[0], right_lo);
      chk("first cm tie", c[1], cm1);
      chk("second cm tie", c[0], cm2);
      gap(1'b1, (c == 0) ? 8 : 8 << (c - 1));
    end
    for (int i = 0; i < 32; i++) begin
      v = 8'(rnd());
      v = {v[0], 3'h0, i[2], 1'b0, i[1:0]};
      hs_en <= i[3];
      hs_in <= i[4];
      acc(1, 7'h2E, v, 0, 8'h00);
      acc(0, 7'h2E, 8'h00, 0, v);
      repeat (6) @(negedge pclk);
      chk("soft powerdown", v[7], spd);
      chk("bias level", (i[2] | ~i[3] | i[4]) ? i[1:0] : 2'b00, mic_bias);
    end
    $display("test driver page done");
    acc(1, 7'h00, 8'h03, 0, 8'h00);
    acc(0, 7'h10, 8'h00, 0, 8'h81);
    gap(1'b0, 8);
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h80 : 8'h83;
      acc(1, 7'h10, v, 0, 8'h00);
      acc(0, 7'h10, 8'h00, 0, v);
      gap(1'b0, k ? 1024 : 24);
    end
    acc(1, 7'h10, 8'h05, 0, 8'h00);
    @(negedge pclk);
    n = 0;
    repeat (300) begin
      @(negedge pclk);
      if (timer_tick !== 1'b0) n++;
    end
    chk("ticks without osc", 0, n);
    osc_run <= 1'b1;
    gap(1'b0, 128);
    $display("test timer done");
    acc(1, 7'h00, 8'h08, 0, 8'h00);
    kk = 5'(rnd());
    if (kk == 5'h1E) kk = 5'h1D;
    dsp_coef_idx <= kk;
    hi = {1'b0, kk, 1'b0} + 7'h02;
    c1 = (kk % 5 == 0) ? 16'h7FFF : 16'h0000;
    acc(0, hi, 8'h00, 0, c1[15:8]);
    acc(0, hi + 7'h01, 8'h00, 0, c1[7:0]);
    c2 = 16'(rnd()) | 16'h8000;
    acc(1, hi, c2[15:8], 0, 8'h00);
    repeat (3) @(negedge pclk);
    chk("dsp coef staged", c1, dsp_coef);
    acc(1, hi + 7'h01, c2[7:0], 0, 8'h00);
    repeat (3) @(negedge pclk);
    chk("dsp coef", c2, dsp_coef);
    acc(1, 7'h01, 8'h04, 0, 8'h00);
    acc(0, 7'h01, 8'h00, 0, 8'h04);
    c1 = 16'(rnd());
    acc(1, hi, c1[15:8], 0, 8'h00);
    acc(1, hi + 7'h01, c1[7:0], 0, 8'h00);
    acc(1, 7'h01, 8'h05, 0, 8'h00);
    acc(0, 7'h01, 8'h00, 0, 8'h05);
    @(negedge pclk);
    chk("adaptive_en", 1, adaptive_en);
    chk("dsp coef before swap", c2, dsp_coef);
    frame();
    @(negedge pclk);
    chk("dsp_buffer_sel", 1, dsp_buffer_sel);
    chk("dsp coef after swap", c1, dsp_coef);
    acc(0, 7'h01, 8'h00, 0, 8'h06);
    acc(0, hi, 8'h00, 0, c2[15:8]);
    acc(1, 7'h01, 8'h01, 0, 8'h00);
    frame();
    acc(0, 7'h01, 8'h00, 0, 8'h03);
    acc(1, 7'h01, 8'h00, 0, 8'h00);
    acc(0, 7'h01, 8'h00, 0, 8'h02);
    $display("test coefficient swap done");
    end_sim();
  end
endmodule : test_paged_ctrl_regs_coef_buffer
`default_nettype wire
